// *** src/kbm_pkg.sv ***
`default_nettype none
package kbm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Host I/O map defaults and relocation indexes
	localparam logic [15:0] DATA_BASE_RST = 16'h0060;
	localparam logic [15:0] CMD_BASE_RST = 16'h0064;
	localparam logic [7:0] CFG_DATA_HI = 8'h60;
	localparam logic [7:0] CFG_DATA_LO = 8'h61;
	localparam logic [7:0] CFG_CMD_HI = 8'h62;
	localparam logic [7:0] CFG_CMD_LO = 8'h63;

	////////////////////////////////////////////////////////////////////////
	// Status bit positions
	localparam int ST_OBF = 0;
	localparam int ST_IBF = 1;
	localparam int ST_SYSF = 2;
	localparam int ST_CMD = 3;
	localparam int ST_INH = 4;
	localparam int ST_AUX = 5;
	localparam int ST_TOUT = 6;
	localparam int ST_PERR = 7;

	////////////////////////////////////////////////////////////////////////
	// Command byte layout and reset value
	localparam int CB_AUX_IE = 1;
	localparam int CB_SYSF = 2;
	localparam int CB_KBD_DIS = 4;
	localparam int CB_AUX_DIS = 5;
	localparam int CB_XLATE = 6;
	localparam logic [7:0] CB_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Controller commands
	localparam logic [7:0] CMD_RD_CB = 8'h20;
	localparam logic [7:0] CMD_WR_CB = 8'h60;
	localparam logic [7:0] CMD_WR_AUX = 8'hd4;

	////////////////////////////////////////////////////////////////////////
	// Channels and serial frame
	localparam int NUM_CH = 2;
	localparam logic CH_KBD = 1'b0;
	localparam logic CH_AUX = 1'b1;
	localparam logic [3:0] BIT_PAR = 4'h8;
	localparam logic [3:0] BIT_STOP = 4'h9;

	////////////////////////////////////////////////////////////////////////
	// Timing: clock line hold before a send, and link time-out
	localparam int CLK_PERIOD_NS = 4;
	localparam int INHIBIT_NS = 100000;
	localparam int TIMEOUT_NS = 2000000;
	localparam int INHIBIT_CYC = (INHIBIT_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 20;

	////////////////////////////////////////////////////////////////////////
	// Pin carriers for one open-drain clock/data pair
	typedef struct packed {
		logic clk_i;
		logic dat_i;
	} kbm_pin_in_t;

	typedef struct packed {
		logic clk_o;
		logic clk_oe;
		logic dat_o;
		logic dat_oe;
	} kbm_pin_out_t;

	////////////////////////////////////////////////////////////////////////
	// State encodings
	typedef enum logic [4:0] {
		CH_IDLE = 5'b00001,
		CH_RX = 5'b00010,
		CH_INH = 5'b00100,
		CH_TX = 5'b01000,
		CH_ACK = 5'b10000
	} kbm_ch_state_t;

	typedef enum logic [3:0] {
		M_IDLE = 4'b0001,
		M_DEC = 4'b0010,
		M_REPLY = 4'b0100,
		M_SEND = 4'b1000
	} kbm_main_state_t;

endpackage
`default_nettype wire

// *** src/kbm_link_chan.sv ***
`default_nettype none
module kbm_link_chan import kbm_pkg::*; #(
	parameter int INH_CYC = INHIBIT_CYC,
	parameter int TO_CYC = TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic disable_link,
	// Open-drain pins
	input wire kbm_pin_in_t pin_in,
	output var kbm_pin_out_t pin_out,
	// Transmit
	input wire logic tx_start,
	input wire logic [7:0] tx_data,
	output logic tx_busy,
	// Receive
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_par_err,
	input wire logic rx_take,
	// Errors
	output logic timeout
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	kbm_ch_state_t state_reg, state_next; // Link sequencer
	logic clk_prev_reg; // Last sampled clock pin
	logic [3:0] bit_reg; // Frame bit index
	logic [9:0] shift_reg; // Frame bits, data first
	logic [CNT_W-1:0] cnt_reg; // Cycles since last clock fall
	logic fall; // Falling edge on clock pin
	logic inh_hit; // Clock hold time reached
	logic to_hit; // Link silent for too long
	logic rx_done; // Stop bit seen

	assign fall = clk_prev_reg & ~pin_in.clk_i;
	assign inh_hit = cnt_reg == CNT_W'(INH_CYC - 1);
	assign to_hit = cnt_reg == CNT_W'(TO_CYC - 1);
	assign rx_done = state_reg == CH_RX && fall && bit_reg == BIT_STOP;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CH_IDLE: begin
				// A send wins over a frame start in the same cycle
				if (tx_start) begin
					state_next = CH_INH;
				end else if (!disable_link && !rx_valid && fall &&
					!pin_in.dat_i) begin
					state_next = CH_RX;
				end
			end
			CH_RX: begin
				if (rx_done || to_hit) begin
					state_next = CH_IDLE;
				end
			end
			CH_INH: begin
				if (inh_hit) begin
					state_next = CH_TX;
				end
			end
			CH_TX: begin
				if (fall && bit_reg == BIT_STOP) begin
					state_next = CH_ACK;
				end else if (to_hit) begin
					state_next = CH_IDLE;
				end
			end
			CH_ACK: begin
				if (fall || to_hit) begin
					state_next = CH_IDLE;
				end
			end
			default: begin
				state_next = CH_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State, edge history and frame bits
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= CH_IDLE;
			clk_prev_reg <= 1'b1;
			bit_reg <= 4'h0;
			shift_reg <= 10'h000;
		end else begin
			state_reg <= state_next;
			clk_prev_reg <= pin_in.clk_i;
			if (state_reg == CH_IDLE) begin
				bit_reg <= 4'h0;
				// Preload stop, odd parity and data for a send
				if (tx_start) begin
					shift_reg <= {1'b1, ~^tx_data, tx_data};
				end
			end else if (fall && (state_reg == CH_RX ||
				state_reg == CH_TX)) begin
				bit_reg <= bit_reg + 4'h1;
				if (state_reg == CH_RX) begin
					shift_reg[bit_reg] <= pin_in.dat_i;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle counter, restarted by every clock fall and state change
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (fall || state_next != state_reg) begin
			cnt_reg <= '0;
		end else if (state_reg != CH_IDLE) begin
			cnt_reg <= cnt_reg + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Received byte holding; parity over data plus parity bit
	// parity checked on receive
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_par_err <= 1'b0;
		end else if (rx_done) begin
			rx_valid <= 1'b1;
			rx_data <= shift_reg[7:0];
			rx_par_err <= ~^shift_reg[8:0];
		end else if (rx_take) begin
			rx_valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Busy covers reception too, so a send only starts from idle
	// busy until acknowledge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy <= 1'b0;
		end else begin
			tx_busy <= state_next != CH_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time-out pulse: silent link or missing acknowledge bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timeout <= 1'b0;
		end else begin
			timeout <= (state_reg != CH_IDLE && !fall && to_hit) ||
				(state_reg == CH_ACK && fall && pin_in.dat_i);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive; clock held low to inhibit while disabled or full
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= '0;
		end else begin
			pin_out.clk_o <= 1'b0;
			pin_out.dat_o <= 1'b0;
			pin_out.clk_oe <= state_next == CH_INH ||
				(state_next == CH_IDLE && (disable_link || rx_valid));
			if (state_reg == CH_INH && state_next == CH_TX) begin
				pin_out.dat_oe <= 1'b1;
			end else if (state_reg == CH_TX && fall) begin
				pin_out.dat_oe <= bit_reg <= BIT_PAR ?
					~shift_reg[bit_reg] : 1'b0;
			end else if (state_next != CH_TX) begin
				pin_out.dat_oe <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// *** src/kbm_host_port.sv ***
`default_nettype none
module kbm_host_port import kbm_pkg::*; #(
	parameter int INH_CYC = INHIBIT_CYC,
	parameter int TO_CYC = TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Host I/O cycles
	input wire logic [15:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_rdata_valid,
	// Relocation configuration writes
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	// Inhibit switch, low when inhibited
	input wire logic kbd_inhibit_n,
	// Keyboard (0) and auxiliary (1) links
	input wire kbm_pin_in_t [NUM_CH-1:0] link_in,
	output wire kbm_pin_out_t [NUM_CH-1:0] link_out,
	// Interrupt requests
	output logic irq_kbd,
	output logic irq_aux
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	kbm_main_state_t state_reg, state_next; // Command sequencer
	logic [15:0] data_base_reg; // Data port address
	logic [15:0] cmd_base_reg; // Command/status port address
	logic [7:0] ibuf_reg; // Input buffer
	logic ibf_reg; // Input buffer full
	logic cmd_flag_reg; // Last write was a command
	logic [7:0] obuf_reg; // Output buffer
	logic obf_reg; // Output buffer full
	logic aux_obf_reg; // Byte came from auxiliary link
	logic perr_reg; // Parity error of last byte
	logic tout_reg; // Sticky link time-out
	logic [7:0] cmd_byte_reg; // Controller command byte
	logic pend_wcb_reg; // Next data is the command byte
	logic pend_aux_reg; // Next data goes to auxiliary link
	logic hit_data, hit_cmd; // Address decode
	logic host_wr_take; // Write accepted into input buffer
	logic ob_read; // Host reads output buffer
	logic consume; // Controller frees input buffer
	logic reply_load; // Command byte goes to output buffer
	logic rx_load; // A received byte goes to output buffer
	logic rx_pick; // Which link is taken
	logic [7:0] status; // Status byte
	// Per-link signals
	logic [NUM_CH-1:0] tx_start, tx_busy, rx_valid, rx_take;
	logic [NUM_CH-1:0] par_err, link_tout, link_dis;
	logic [7:0] rx_data [NUM_CH];

	////////////////////////////////////////////////////////////////////////
	// Address decode and port actions
	// compare against relocatable bases
	assign hit_data = io_addr == data_base_reg;
	assign hit_cmd = io_addr == cmd_base_reg;
	assign host_wr_take = io_wr && (hit_data || hit_cmd) && !ibf_reg;
	assign ob_read = io_rd && hit_data;

	////////////////////////////////////////////////////////////////////////
	// Serial links, one per channel
	assign link_dis[CH_KBD] = cmd_byte_reg[CB_KBD_DIS];
	assign link_dis[CH_AUX] = cmd_byte_reg[CB_AUX_DIS];

	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : g_link
			kbm_link_chan #(
				.INH_CYC(INH_CYC),
				.TO_CYC(TO_CYC)
			) u_link (
				.clock(clock),
				.rst_n(rst_n),
				.disable_link(link_dis[i]),
				.pin_in(link_in[i]),
				.pin_out(link_out[i]),
				.tx_start(tx_start[i]),
				.tx_data(ibuf_reg),
				.tx_busy(tx_busy[i]),
				.rx_valid(rx_valid[i]),
				.rx_data(rx_data[i]),
				.rx_par_err(par_err[i]),
				.rx_take(rx_take[i]),
				.timeout(link_tout[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Command sequencer decisions
	always_comb begin
		state_next = state_reg;
		consume = 1'b0;
		reply_load = 1'b0;
		tx_start = '0;
		case (state_reg)
			M_IDLE: begin
				if (ibf_reg) begin
					state_next = M_DEC;
				end
			end
			M_DEC: begin
				if (cmd_flag_reg) begin
					if (ibuf_reg == CMD_RD_CB) begin
						state_next = M_REPLY;
					end else begin
						// Other commands only set or clear a pending parameter
						consume = 1'b1;
						state_next = M_IDLE;
					end
				end else if (pend_wcb_reg) begin
					consume = 1'b1;
					state_next = M_IDLE;
				end else begin
					state_next = M_SEND;
				end
			end
			M_REPLY: begin
				// Wait for the host to empty the buffer first
				if (!obf_reg) begin
					reply_load = 1'b1;
					consume = 1'b1;
					state_next = M_IDLE;
				end
			end
			M_SEND: begin
				// start only on an idle link
				if (!tx_busy[pend_aux_reg]) begin
					tx_start[pend_aux_reg] = 1'b1;
					consume = 1'b1;
					state_next = M_IDLE;
				end
			end
			default: begin
				state_next = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= M_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Received byte selection; keyboard first, reply before both
	always_comb begin
		rx_pick = rx_valid[CH_KBD] ? CH_KBD : CH_AUX;
		rx_load = !obf_reg && !reply_load && |rx_valid;
		rx_take = '0;
		rx_take[rx_pick] = rx_load;
	end

	////////////////////////////////////////////////////////////////////////
	// Output buffer; a load in the read cycle keeps the flag set
	// received byte into output buffer
	// full on load, empty on host read
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			obuf_reg <= 8'h00;
			obf_reg <= 1'b0;
			aux_obf_reg <= 1'b0;
			perr_reg <= 1'b0;
		end else if (reply_load) begin
			obuf_reg <= cmd_byte_reg;
			obf_reg <= 1'b1;
			aux_obf_reg <= 1'b0;
			perr_reg <= 1'b0;
		end else if (rx_load) begin
			obuf_reg <= rx_data[rx_pick];
			obf_reg <= 1'b1;
			aux_obf_reg <= rx_pick == CH_AUX;
			perr_reg <= par_err[rx_pick];
		end else if (ob_read) begin
			obf_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time-out flag; a new error wins over the clear by any received byte, parity error or not
	// sticky link time-out
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tout_reg <= 1'b0;
		end else if (|link_tout) begin
			tout_reg <= 1'b1;
		end else if (rx_load) begin
			tout_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input buffer and command/data flag
	// host write fills buffer
	// full on write, empty when consumed
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ibuf_reg <= 8'h00;
			ibf_reg <= 1'b0;
			cmd_flag_reg <= 1'b0;
		end else if (host_wr_take) begin
			ibuf_reg <= io_wdata;
			ibf_reg <= 1'b1;
			cmd_flag_reg <= hit_cmd;
		end else if (consume) begin
			ibf_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pending parameter; any new command cancels the old one
	// track awaited parameter byte
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_wcb_reg <= 1'b0;
			pend_aux_reg <= 1'b0;
		end else if (state_reg == M_DEC && cmd_flag_reg) begin
			pend_wcb_reg <= ibuf_reg == CMD_WR_CB;
			pend_aux_reg <= ibuf_reg == CMD_WR_AUX;
		end else if (consume) begin
			pend_wcb_reg <= 1'b0;
			pend_aux_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command byte; translate bit is stored only, no code translation
	// write command byte parameter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_byte_reg <= CB_RST;
		end else if (state_reg == M_DEC && !cmd_flag_reg && pend_wcb_reg) begin
			cmd_byte_reg <= ibuf_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Relocation registers
	// configuration writes move ports
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_base_reg <= DATA_BASE_RST;
			cmd_base_reg <= CMD_BASE_RST;
		end else if (cfg_wr) begin
			case (cfg_index)
				CFG_DATA_HI: data_base_reg[15:8] <= cfg_wdata;
				CFG_DATA_LO: data_base_reg[7:0] <= cfg_wdata;
				CFG_CMD_HI: cmd_base_reg[15:8] <= cfg_wdata;
				CFG_CMD_LO: cmd_base_reg[7:0] <= cfg_wdata;
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status byte
	always_comb begin
		status = 8'h00;
		status[ST_OBF] = obf_reg;
		status[ST_IBF] = ibf_reg;
		status[ST_SYSF] = cmd_byte_reg[CB_SYSF];
		status[ST_CMD] = cmd_flag_reg;
		status[ST_INH] = kbd_inhibit_n;
		status[ST_AUX] = aux_obf_reg;
		status[ST_TOUT] = tout_reg;
		status[ST_PERR] = perr_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data; a status read touches no buffer
	// data port returns output buffer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
			io_rdata_valid <= 1'b0;
		end else begin
			io_rdata_valid <= io_rd && (hit_data || hit_cmd);
			if (io_rd && hit_data) begin
				io_rdata <= obuf_reg;
			end else if (io_rd && hit_cmd) begin
				io_rdata <= status;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts as levels while a byte waits
	// request while buffer full
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_kbd <= 1'b0;
			irq_aux <= 1'b0;
		end else begin
			irq_kbd <= obf_reg && !aux_obf_reg;
			irq_aux <= obf_reg && aux_obf_reg && cmd_byte_reg[CB_AUX_IE];
		end
	end

endmodule
`default_nettype wire

// *** verif/kbm_host_port_chk.sv ***
`default_nettype none
module kbm_host_port_chk import kbm_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Host cycles
	input wire logic [15:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	input wire logic kbd_inhibit_n,
	// Links and interrupts
	input wire kbm_pin_out_t [NUM_CH-1:0] link_out,
	input wire logic irq_kbd,
	input wire logic irq_aux
);
	timeunit 1ns;
	timeprecision 1ps;
	// Shadow bases, so relocated ports still decode
	logic [15:0] dbase_reg;
	logic [15:0] cbase_reg;
	logic hit_d;
	logic hit_c;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	assign hit_d = io_addr == dbase_reg;
	assign hit_c = io_addr == cbase_reg;
	////////////////////////////////////////
	// Follow relocation writes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dbase_reg <= DATA_BASE_RST;
			cbase_reg <= CMD_BASE_RST;
		end else if (cfg_wr) begin
			case (cfg_index)
			CFG_DATA_HI: dbase_reg[15:8] <= cfg_wdata;
			CFG_DATA_LO: dbase_reg[7:0] <= cfg_wdata;
			CFG_CMD_HI: cbase_reg[15:8] <= cfg_wdata;
			CFG_CMD_LO: cbase_reg[7:0] <= cfg_wdata;
			default: ;
			endcase
		end
	end
	read_answer_a: assert property (
		io_rd && (hit_d || hit_c) |=> io_rdata_valid) else $error("no answer");
	stray_answer_a: assert property (
		io_rdata_valid |-> $past(io_rd) && ($past(hit_d) || $past(hit_c)))
		else $error("stray answer");
	cmd_flag_a: assert property (
		io_wr && hit_c ##2 io_rd && hit_c |=> io_rdata[ST_IBF] &&
		io_rdata[ST_CMD]) else $error("command flag wrong");
	data_flag_a: assert property (
		io_wr && hit_d ##2 io_rd && hit_c |=> io_rdata[ST_IBF] &&
		!io_rdata[ST_CMD]) else $error("data flag wrong");
	inhibit_bit_a: assert property (
		io_rd && hit_c |=> io_rdata[ST_INH] == $past(kbd_inhibit_n))
		else $error("inhibit bit wrong");
	aux_source_a: assert property (
		io_rd && hit_c && irq_aux |=> io_rdata[ST_AUX])
		else $error("aux source bit wrong");
	irq_clear_a: assert property (
		io_rd && hit_d && irq_kbd |-> ##[1:3] !irq_kbd)
		else $error("request not cleared");
	kbd_hold_a: assert property (
		$fell(irq_kbd) |-> $past(io_rd && hit_d, 2)) else $error("early drop");
	open_drain_a: assert property (
		!(link_out[0].clk_o | link_out[0].dat_o | link_out[1].clk_o |
		link_out[1].dat_o)) else $error("line driven high");
	// Main scenarios reached
	cover property (irq_kbd);
	cover property (irq_aux);
	cover property (io_wr && hit_c ##2 io_rd && hit_c);
endmodule
bind kbm_host_port kbm_host_port_chk kbm_host_port_chk_i (.clock(clock),
	.rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
	.io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .cfg_wr(cfg_wr),
	.cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .link_out(link_out),
	.kbd_inhibit_n(kbd_inhibit_n), .irq_kbd(irq_kbd), .irq_aux(irq_aux));
`default_nettype wire

// *** verif/kbm_dev_model.sv ***
`default_nettype none
module kbm_dev_model (
	// Clock
	input wire logic clock,
	// Resolved lines and fault control
	input wire logic clk_line,
	input wire logic dat_line,
	input wire logic no_ack,
	// Pull-downs
	output logic clk_pull,
	output logic dat_pull,
	// Bytes taken from the controller
	output logic [7:0] got_byte,
	output int got_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half period of the device clock, in system clocks
	localparam int HALF = 4;
	logic sending = 1'b0;
	logic [9:0] bits;
	initial begin
		clk_pull = 1'b0;
		dat_pull = 1'b0;
		got_byte = 8'h00;
		got_cnt = 0;
	end
	task automatic tick;
		repeat (HALF) @(posedge clock);
	endtask
	// Frame out: start, data LSB first, parity, stop
	task automatic send_frame(input logic [7:0] b, input logic bad);
		logic [10:0] f;
		f = {1'b1, ~(^b) ^ bad, b, 1'b0};
		sending = 1'b1;
		// Wait while the controller holds the clock low
		do @(posedge clock); while (!clk_line);
		for (int i = 0; i < 11; i++) begin
			dat_pull <= ~f[i];
			tick();
			clk_pull <= 1'b1;
			tick();
			clk_pull <= 1'b0;
		end
		dat_pull <= 1'b0;
		sending = 1'b0;
	endtask
	////////////////////////////////////////
	// Request to send: clock released, data low
	always begin
		@(posedge clock);
		if (!sending && clk_line && !dat_line) begin
			for (int i = 0; i < 10; i++) begin
				tick();
				clk_pull <= 1'b1;
				tick();
				bits[i] = dat_line;
				clk_pull <= 1'b0;
			end
			tick();
			dat_pull <= !no_ack;
			clk_pull <= 1'b1;
			tick();
			clk_pull <= 1'b0;
			dat_pull <= 1'b0;
			got_byte = bits[7:0];
			got_cnt++;
		end
	end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
module tb_top import kbm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, io_rd, io_wr, io_rdata_valid, cfg_wr;
	logic kbd_inhibit_n, irq_kbd, irq_aux, no_ack;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, cfg_index, cfg_wdata, kgot, agot;
	logic [1:0] cpl, dpl;
	kbm_pin_in_t [NUM_CH-1:0] link_in;
	wire kbm_pin_out_t [NUM_CH-1:0] link_out;
	int kcnt, acnt;
	int total_checks = 0;
	int miscompares = 0;
	// Pull-ups: a line is low while either side pulls
	assign link_in[0].clk_i = ~(link_out[0].clk_oe | cpl[0]);
	assign link_in[0].dat_i = ~(link_out[0].dat_oe | dpl[0]);
	assign link_in[1].clk_i = ~(link_out[1].clk_oe | cpl[1]);
	assign link_in[1].dat_i = ~(link_out[1].dat_oe | dpl[1]);
	// Short counts keep the run brief
	kbm_host_port #(.INH_CYC(8), .TO_CYC(200)) kbm_host_port_i (
		.clock(clock), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
		.io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.io_rdata_valid(io_rdata_valid), .cfg_wr(cfg_wr),
		.cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
		.kbd_inhibit_n(kbd_inhibit_n), .link_in(link_in),
		.link_out(link_out), .irq_kbd(irq_kbd), .irq_aux(irq_aux));
	kbm_dev_model kbd_dev_i (.clock(clock), .clk_line(link_in[0].clk_i),
		.dat_line(link_in[0].dat_i), .no_ack(1'b0), .clk_pull(cpl[0]),
		.dat_pull(dpl[0]), .got_byte(kgot), .got_cnt(kcnt));
	kbm_dev_model aux_dev_i (.clock(clock), .clk_line(link_in[1].clk_i),
		.dat_line(link_in[1].dat_i), .no_ack(no_ack), .clk_pull(cpl[1]),
		.dat_pull(dpl[1]), .got_byte(agot), .got_cnt(acnt));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	////////////////////////////////////////
	task automatic check(input string n, input logic [8:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// One write pulse; writes have no answer
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clock);
		io_wr <= 1'b0;
	endtask
	// Answer is registered at the taking edge and read at the falling edge after it
	task automatic rd(input logic [15:0] a, output logic [8:0] r);
		@(posedge clock);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clock);
		io_rd <= 1'b0;
		@(negedge clock);
		r = {io_rdata_valid, io_rdata};
	endtask
	task automatic chk_rd(input string n, input logic [15:0] a,
		input logic [7:0] m, e);
		logic [8:0] r;
		rd(a, r);
		check(n, {r[8], r[7:0] & m}, {1'b1, e});
	endtask
	// Poll status until the masked bits match, bounded
	task automatic wait_st(input logic [7:0] m, v);
		logic [8:0] r;
		for (int i = 0; i < 400; i++) begin
			rd(CMD_BASE_RST, r);
			if ((r[7:0] & m) === v) break;
		end
		check("status", {1'b0, r[7:0] & m}, {1'b0, v});
	endtask
	task automatic cfg(input logic [7:0] i, d);
		@(posedge clock);
		cfg_index <= i;
		cfg_wdata <= d;
		cfg_wr <= 1'b1;
		@(posedge clock);
		cfg_wr <= 1'b0;
	endtask
	task automatic test_done;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		test_done();
	end
	////////////////////////////////////////
	initial begin
		logic [8:0] r;
		{io_rd, io_wr, cfg_wr, no_ack, rst_n} = 5'h00;
		{io_addr, io_wdata, cfg_index, cfg_wdata} = 40'h0;
		kbd_inhibit_n = 1'b1;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		chk_rd("status reset", CMD_BASE_RST, 8'hff, 8'h10);
		@(posedge clock);
		kbd_inhibit_n <= 1'b0;
		chk_rd("inhibit", CMD_BASE_RST, 8'h10, 8'h00);
		@(posedge clock);
		kbd_inhibit_n <= 1'b1;
		// Command byte: translate, system flag, aux interrupt
		wr(CMD_BASE_RST, CMD_WR_CB);
		chk_rd("cmd flag", CMD_BASE_RST, 8'h0a, 8'h0a);
		wait_st(8'h02, 8'h00);
		wr(DATA_BASE_RST, 8'h46);
		chk_rd("data flag", CMD_BASE_RST, 8'h0a, 8'h02);
		wait_st(8'h06, 8'h04);
		wr(CMD_BASE_RST, CMD_RD_CB);
		wait_st(8'h01, 8'h01);
		chk_rd("cmd byte", DATA_BASE_RST, 8'hff, 8'h46);
		check("irq kbd", {8'h00, irq_kbd}, 9'h001);
		wait_st(8'h01, 8'h00);
		// Good keyboard byte, then aux byte with bad parity
		kbd_dev_i.send_frame(8'ha5, 1'b0);
		wait_st(8'he1, 8'h01);
		chk_rd("kbd byte", DATA_BASE_RST, 8'hff, 8'ha5);
		aux_dev_i.send_frame(8'h3c, 1'b1);
		wait_st(8'he1, 8'ha1);
		chk_rd("aux status", CMD_BASE_RST, 8'h20, 8'h20);
		chk_rd("aux byte", DATA_BASE_RST, 8'hff, 8'h3c);
		check("irq aux", {7'h00, irq_aux, irq_kbd}, 9'h002);
		// Two keyboard bytes back to back must not overlap
		wr(DATA_BASE_RST, 8'hed);
		wait_st(8'h02, 8'h00);
		wr(DATA_BASE_RST, 8'h55);
		for (int i = 0; i < 900 && kcnt < 1; i++) @(posedge clock);
		check("kbd got 1", {1'b0, kgot}, 9'h0ed);
		for (int i = 0; i < 900 && kcnt < 2; i++) @(posedge clock);
		check("kbd got 2", {1'b0, kgot}, 9'h055);
		check("kbd count", kcnt[8:0], 9'h002);
		// Aux byte, then one left unacknowledged
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			no_ack <= k[0];
			wr(CMD_BASE_RST, CMD_WR_AUX);
			wait_st(8'h02, 8'h00);
			wr(DATA_BASE_RST, 8'hf4);
			for (int i = 0; i < 900 && acnt <= k; i++) @(posedge clock);
			check("aux got", {1'b0, agot}, 9'h0f4);
		end
		wait_st(8'h40, 8'h40);
		@(posedge clock);
		no_ack <= 1'b0;
		kbd_dev_i.send_frame(8'h12, 1'b0);
		wait_st(8'hc1, 8'h01);
		chk_rd("kbd byte 2", DATA_BASE_RST, 8'hff, 8'h12);
		// Keyboard disable holds its clock low, aux stays free
		wr(CMD_BASE_RST, CMD_WR_CB);
		wait_st(8'h02, 8'h00);
		wr(DATA_BASE_RST, 8'h10);
		wait_st(8'h06, 8'h00);
		check("kbd held", {7'h00, link_out[1].clk_oe,
			link_out[0].clk_oe}, 9'h001);
		// Move both ports; the old address goes quiet
		cfg(CFG_DATA_HI, 8'h03);
		cfg(CFG_DATA_LO, 8'h00);
		cfg(CFG_CMD_HI, 8'h03);
		cfg(CFG_CMD_LO, 8'h04);
		rd(CMD_BASE_RST, r);
		check("old base", {8'h00, r[8]}, 9'h000);
		chk_rd("new base", 16'h0304, 8'h11, 8'h10);
		test_done();
	end
endmodule
`default_nettype wire
